// [pkg/microcode_sequencer_regs.svh]
`ifndef MICROCODE_SEQUENCER_REGS_SVH
`define MICROCODE_SEQUENCER_REGS_SVH

// Register offsets on the plain port
`define OFS_MC_ADDR     8'h00
`define OFS_MC_LOW      8'h04
`define OFS_MC_HIGH     8'h08
`define OFS_TERM_ADDR   8'h0C
`define OFS_TERM_DATA   8'h10
`define OFS_STATUS      8'h14
`define OFS_CTRL        8'h18

// Microword field positions
`define F_LSB           0
`define Q_LSB           16
`define D_LSB           24
`define OP_LSB          32
`define E_BIT           35
`define WORD_BITS       36

// Store and branch geometry
`define STORE_WORDS     9'h1C0
`define LAST_WORD       9'h1BF
`define MULTI_BASE      8'hC0
`define TERM_COUNT      10'h300
`define LAST_TERM       10'h2FF
`define TERMS_PER_LOC   12
`define TERMS_PER_COND  4

// Control and reset values
`define CTRL_RESTART    0
`define CNT_RESET       8'h00
`define DEPTH_RESET     4'h0
`define RESET_HOLD      3

`endif

// [pkg/microcode_sequencer_pkg.sv]
package microcode_sequencer_pkg;

	typedef enum logic [2:0] {
		OP_JUMP     = 3'h0,
		OP_JUMP_D   = 3'h1,
		OP_CALL     = 3'h2,
		OP_RETURN   = 3'h3,
		OP_LOADC    = 3'h4,
		OP_LOOPNZ   = 3'h5,
		OP_PUSH_IN  = 3'h6,
		OP_POP_CNT  = 3'h7
	} opcode_type;

	typedef logic [7:0] addr_type;

endpackage : microcode_sequencer_pkg

// [rtl/microcode_store.sv]
module microcode_store #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 448,
	parameter int AW    = 9
) (
	input  wire logic             mclk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_ff
);

	logic [WIDTH-1:0] mem [DEPTH];

	initial begin
		if (DEPTH > (1 << AW) || WIDTH < 1)
			$error("microcode_store: depth does not fit address width");
	end

	// No reset: content survives a master reset, the read register is reloaded
	always_ff @(posedge mclk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_ff <= mem[rd_addr];
	end

endmodule : microcode_store

// [rtl/microcode_sequencer_core.sv]
// How it works
// - Store holds 448 words of 36 bits, one per single location, four per multiway location.
// - Sixteen output bits of the current word drive the user outputs.
// - Word carries 8-bit next address and 8-bit constant/alternate address.
// - A 3-bit opcode field picks the sequencing instruction.
// - One enable bit per word drives or floats the user outputs.
// - Addresses 0 to 191 map to exactly one word each.
// - Selected word loads into the pipeline register every rising edge.
// - Addresses 192 to 255 each hold four words .0 to .3.
// - In the multiway range address plus conditions pick one of four.
// - Next address comes from next-address field, constant field or stack top.
// - Source chosen by current opcode and loop counter zero flag.
// - Branch select is 768 product terms over 16 literals, 3 outputs.
// - Below 192 branch select is off and the word is used unchanged.
// - Highest true condition wins: .3, then .2, then .1, else .0.
// - Each condition is an OR of at most four product terms.
// - Each of 64 multiway locations owns its own 12 terms.
// - Branch decision uses inputs, current word and terms within one clock.
// - Fifteen-entry 8-bit stack and 8-bit loop counter feed branch control.
// - After each load next address comes from new word, counter, stack, inputs.
// - Pop on empty gives zero; push on full overwrites the top only.
// - Counter decrements, sticks at zero, zero flag raised at zero.
// - Enable bit 1 drives all user outputs, 0 floats them.
// - Reset held three edges empties stack, clears counter, loads word 0.
`include "microcode_sequencer_regs.svh"

module microcode_sequencer_core
	import microcode_sequencer_pkg::*;
#(
	parameter int STACK_DEPTH = 15
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  cond_in,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic      [15:0] user_out,
	output logic             user_out_oe_n
);

	typedef struct packed {
		logic [`TERM_COUNT-1:0][15:0] terms;
		logic [14:0][7:0]             stk;
		logic [3:0]                   depth;
		logic [7:0]                   cnt;
		logic [8:0]                   mc_addr;
		logic [31:0]                  mc_low;
		logic [9:0]                   term_addr;
		logic [31:0]                  rdata;
	} state_type;

	state_type               state_ff;
	state_type               nxt_state;
	logic [`WORD_BITS-1:0]   pipe;
	opcode_type              op;
	addr_type                q_field;
	addr_type                d_field;
	addr_type                tos;
	addr_type                next_addr;
	logic                    zero;
	logic                    multi;
	logic [5:0]              loc;
	logic [2:0]              cond;
	logic [1:0]              sel;
	logic [8:0]              phys_idx;
	logic [8:0]              rd_idx;
	logic                    restart;
	logic                    push;
	logic                    pop;
	addr_type                push_val;
	logic                    mc_we;
	logic [`WORD_BITS-1:0]   mc_wdata;

	initial begin
		if (STACK_DEPTH < 1 || STACK_DEPTH > 15)
			$error("microcode_sequencer_core: stack depth must be 1 to 15");
	end

	// Literal set: true inputs low byte, complements high byte
	function automatic logic term_hit(input logic [15:0] mask, input logic [7:0] pins);
		logic [15:0] lits;
		lits = {~pins, pins};
		// Empty mask marks an unused term, not a constant true
		term_hit = (mask != 16'h0000) && ((~mask | lits) == 16'hFFFF);
	endfunction : term_hit

	function automatic logic cond_eval(
		input logic [`TERM_COUNT-1:0][15:0] t,
		input logic [5:0]                   where,
		input int                           which,
		input logic [7:0]                   pins
	);
		int base;
		cond_eval = 1'b0;
		base = int'(where) * `TERMS_PER_LOC + which * `TERMS_PER_COND;
		for (int k = 0; k < `TERMS_PER_COND; k++) begin
			cond_eval = cond_eval | term_hit(t[base + k], pins);
		end
	endfunction : cond_eval

	microcode_store #(
		.WIDTH (`WORD_BITS),
		.DEPTH (int'(`STORE_WORDS)),
		.AW    (9)
	) u_store (
		.mclk       (mclk),
		.wr_en      (mc_we),
		.wr_addr    (state_ff.mc_addr),
		.wr_data    (mc_wdata),
		.rd_addr    (rd_idx),
		.rd_data_ff (pipe)
	);

	// Enable bit kept inverted in the store so the pin enable is a flop bit
	assign user_out      = pipe[`F_LSB +: 16];
	assign user_out_oe_n = pipe[`E_BIT];
	assign reg_rdata     = state_ff.rdata;

	assign op      = opcode_type'(pipe[`OP_LSB +: 3]);
	assign q_field = pipe[`Q_LSB +: 8];
	assign d_field = pipe[`D_LSB +: 8];
	assign zero    = (state_ff.cnt == 8'h00);
	assign tos     = (state_ff.depth == 4'h0) ? 8'h00 : state_ff.stk[state_ff.depth - 4'h1];

	assign restart  = reg_wr && (reg_addr == `OFS_CTRL) && reg_wdata[`CTRL_RESTART];
	assign mc_we    = reg_wr && (reg_addr == `OFS_MC_HIGH);
	assign mc_wdata = {~reg_wdata[3], reg_wdata[2:0], state_ff.mc_low};

	// Address source from opcode and zero flag
	always_comb begin
		next_addr = q_field;
		push      = 1'b0;
		pop       = 1'b0;
		push_val  = q_field;
		case (op)
			OP_JUMP:    next_addr = q_field;
			OP_JUMP_D:  next_addr = d_field;
			OP_CALL: begin
				next_addr = d_field;
				push      = 1'b1;
			end
			OP_RETURN: begin
				next_addr = tos;
				pop       = 1'b1;
			end
			OP_LOADC:   next_addr = q_field;
			OP_LOOPNZ:  next_addr = zero ? q_field : d_field;
			OP_PUSH_IN: begin
				push      = 1'b1;
				push_val  = cond_in;
			end
			OP_POP_CNT: pop = 1'b1;
			default:    next_addr = q_field;
		endcase
	end

	assign multi = (next_addr >= `MULTI_BASE);
	assign loc   = next_addr[5:0];

	// One OR-of-terms per condition, each location with its own 12 terms
	for (genvar c = 0; c < 3; c++) begin : g_cond
		assign cond[c] = multi && cond_eval(state_ff.terms, loc, c, cond_in);
	end

	// Priority select settles combinationally before the loading edge
	assign sel = cond[2] ? 2'd3 : cond[1] ? 2'd2 : cond[0] ? 2'd1 : 2'd0;

	assign phys_idx = multi ? ({1'b0, `MULTI_BASE} + {1'b0, loc, sel}) : {1'b0, next_addr};
	// Word 0 is reloaded on every edge while reset is low
	assign rd_idx = (!rst_b || restart) ? 9'h000 : phys_idx;

	always_comb begin
		nxt_state       = state_ff;
		nxt_state.rdata = 32'h0000_0000;
		// Sequencing side: stack and counter
		if (restart) begin
			nxt_state.cnt   = `CNT_RESET;
			nxt_state.depth = `DEPTH_RESET;
			nxt_state.stk   = '0;
		end else begin
			if (push) begin
				if (state_ff.depth == 4'(STACK_DEPTH))
					nxt_state.stk[state_ff.depth - 4'h1] = push_val;
				else begin
					nxt_state.stk[state_ff.depth] = push_val;
					nxt_state.depth = state_ff.depth + 4'h1;
				end
			end
			if (pop) begin
				if (state_ff.depth != 4'h0)
					nxt_state.depth = state_ff.depth - 4'h1;
			end
			if (op == OP_LOADC)
				nxt_state.cnt = d_field;
			else if (op == OP_POP_CNT)
				nxt_state.cnt = tos;
			else if (op == OP_LOOPNZ && !zero)
				nxt_state.cnt = state_ff.cnt - 8'h01;
		end
		// Programming side
		if (reg_wr) begin
			case (reg_addr)
				`OFS_MC_ADDR:   nxt_state.mc_addr = reg_wdata[8:0];
				`OFS_MC_LOW:    nxt_state.mc_low = reg_wdata;
				`OFS_MC_HIGH: begin
					nxt_state.mc_addr = (state_ff.mc_addr == `LAST_WORD) ? 9'h000 : state_ff.mc_addr + 9'h001;
				end
				`OFS_TERM_ADDR: nxt_state.term_addr = reg_wdata[9:0];
				`OFS_TERM_DATA: begin
					if (state_ff.term_addr <= `LAST_TERM)
						nxt_state.terms[state_ff.term_addr] = reg_wdata[15:0];
					nxt_state.term_addr = (state_ff.term_addr >= `LAST_TERM) ? 10'h000
						: state_ff.term_addr + 10'h001;
				end
				default: nxt_state.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`OFS_MC_ADDR:   nxt_state.rdata = {23'h0, state_ff.mc_addr};
				`OFS_MC_LOW:    nxt_state.rdata = state_ff.mc_low;
				`OFS_TERM_ADDR: nxt_state.rdata = {22'h0, state_ff.term_addr};
				`OFS_STATUS:    nxt_state.rdata = {11'h0, zero, state_ff.depth, tos, state_ff.cnt};
				default:        nxt_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Reset also clears the terms: program them after reset, then restart
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	chk_single_index: assert property (
		!multi |-> (phys_idx == {1'b0, next_addr}) && (sel == 2'd0))
		else $error("single location index wrong");

	chk_multi_index: assert property (
		multi |-> (phys_idx == 9'(int'(next_addr) * 4 - 576 + int'(sel))))
		else $error("multiway index wrong");

	chk_prio_top: assert property (
		(multi && cond[2]) |-> (sel == 2'd3))
		else $error("highest condition did not win");

	chk_prio_none: assert property (
		(multi && cond == 3'b000) |-> (sel == 2'd0))
		else $error("default word not chosen");

	chk_prio_low: assert property (
		(cond == 3'b001) |-> (sel == 2'd1) && multi)
		else $error("lowest condition select wrong");

	chk_cnt_stick: assert property (
		(zero && op == OP_LOOPNZ && !restart) |=> zero)
		else $error("counter wrapped below zero");

	chk_cnt_step: assert property (
		(!zero && op == OP_LOOPNZ && !restart) |=> (state_ff.cnt == $past(state_ff.cnt) - 8'h01))
		else $error("counter did not step down");

	chk_pop_empty: assert property (
		(state_ff.depth == 4'h0 && op == OP_RETURN) |-> (next_addr == 8'h00))
		else $error("empty pop not zero");

	chk_push_full: assert property (
		(state_ff.depth == 4'(STACK_DEPTH) && push && !restart) |=>
			(state_ff.depth == 4'(STACK_DEPTH)) && (tos == $past(push_val)))
		else $error("full push misbehaved");

	chk_restart_clear: assert property (
		restart |=> (state_ff.depth == 4'h0) && zero)
		else $error("restart did not clear stack and counter");

	chk_mux_source: assert property (
		(op == OP_LOOPNZ) |-> (next_addr == (zero ? q_field : d_field)))
		else $error("loop source wrong");

	// Address source per opcode; implications keep an unprogrammed word quiet
	chk_q_source: assert property (
		(op == OP_JUMP || op == OP_LOADC || op == OP_PUSH_IN || op == OP_POP_CNT) |-> (next_addr == q_field))
		else $error("next address not from next-address field");

	chk_d_source: assert property (
		(op == OP_JUMP_D || op == OP_CALL) |-> (next_addr == d_field))
		else $error("next address not from constant field");

	chk_return_src: assert property (
		(op == OP_RETURN && state_ff.depth != 4'h0) |-> (next_addr == tos))
		else $error("return not taken from stack top");

	chk_prio_mid: assert property (
		(multi && !cond[2] && cond[1]) |-> (sel == 2'd2))
		else $error("middle condition select wrong");

	chk_branch_off: assert property (
		!multi |-> (cond == 3'b000))
		else $error("branch select active below multiway range");

	chk_index_range: assert property (
		multi |-> (phys_idx <= `LAST_WORD))
		else $error("multiway index beyond store");

	chk_restart_word0: assert property (
		restart |-> (rd_idx == 9'h000))
		else $error("restart did not address word 0");

	// Stack and counter moves; a restart overrides both, so it is excluded
	chk_push_step: assert property (
		(push && state_ff.depth != 4'(STACK_DEPTH) && !restart) |=>
			(state_ff.depth == $past(state_ff.depth) + 4'h1) && (tos == $past(push_val)))
		else $error("push did not grow the stack");

	chk_pop_step: assert property (
		(pop && state_ff.depth != 4'h0 && !restart) |=> (state_ff.depth == $past(state_ff.depth) - 4'h1))
		else $error("pop did not shrink the stack");

	chk_cnt_load: assert property (
		(op == OP_LOADC && !restart) |=> (state_ff.cnt == $past(d_field)))
		else $error("counter not loaded from constant field");

	chk_pop_count: assert property (
		(op == OP_POP_CNT && !restart) |=> (state_ff.cnt == $past(tos)))
		else $error("counter not loaded from stack top");

	cov_multi_top: cover property (multi && sel == 2'd3);
	cov_call_return: cover property ((op == OP_CALL) ##[1:20] (op == OP_RETURN));
	cov_loop_done: cover property ((op == OP_LOOPNZ && !zero) ##1 (op == OP_LOOPNZ && zero));
	cov_full_push: cover property (state_ff.depth == 4'(STACK_DEPTH) && push);
	cov_multi_none: cover property (multi && sel == 2'd0);

endmodule : microcode_sequencer_core

// [tb/far_side_model.sv]
module far_side_model (
	input  wire logic        mclk,
	input  wire logic [15:0] user_out,
	input  wire logic        user_out_oe_n,
	input  wire logic [7:0]  cond_set,
	output logic      [7:0]  cond_in,
	output logic      [15:0] pins
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0]  cond_ff = 8'h00;
	logic [15:0] last_ff;

	// Conditions change only just after an edge, like a synchronous source
	always @(posedge mclk) begin
		cond_ff <= cond_set;
	end
	always @(posedge mclk) begin
		if (!user_out_oe_n) begin
			last_ff <= user_out;
		end
	end
	assign cond_in = cond_ff;
	// Released bus shows a changed value, so a stale level never passes
	assign pins = user_out_oe_n ? ~last_ff : user_out;
endmodule : far_side_model

// [tb/testbench.sv]
`include "microcode_sequencer_regs.svh"

module testbench
	import microcode_sequencer_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk;
	logic        rst_b;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [15:0] user_out;
	logic        user_out_oe_n;
	logic [7:0]  cond_in;
	logic [7:0]  cond_set;
	logic [15:0] pins;
	int          err_count;
	int          total_checks;
	logic [15:0] seq_f [14] = '{16'h1000, 16'h1001, 16'h1002, 16'h1002, 16'h1002, 16'h1003, 16'h1005,
		16'h1004, 16'h1006, 16'h0000, 16'h1007, 16'h1009, 16'h100A, 16'h1000};
	logic [7:0]  vec [6] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h10, 8'h90};
	logic [15:0] br_f [6] = '{16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2003, 16'h2000};

	microcode_sequencer_core DUT (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.cond_in       (cond_in),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.user_out      (user_out),
		.user_out_oe_n (user_out_oe_n)
	);

	far_side_model far_side (
		.mclk          (mclk),
		.user_out      (user_out),
		.user_out_oe_n (user_out_oe_n),
		.cond_set      (cond_set),
		.cond_in       (cond_in),
		.pins          (pins)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, e);
	endtask : rd

	// Word goes in as low half then high half; high half commits it
	task automatic pw(input logic [8:0] idx, input logic e, input opcode_type op, input logic [7:0] d,
		input logic [7:0] q, input logic [15:0] f);
		wr(`OFS_MC_ADDR, {23'h0, idx});
		wr(`OFS_MC_LOW, {d, q, f});
		wr(`OFS_MC_HIGH, {28'h0, e, op});
	endtask : pw

	task automatic await_f(input logic [15:0] f);
		int n;
		n = 0;
		// Let the edge that may have launched a new word settle first
		#1;
		while (user_out !== f && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (user_out !== f) begin
			err_count++;
			report_and_stop();
		end
	endtask : await_f

	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cond_set = 8'h00;
		err_count = 0;
		total_checks = 0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		rd(`OFS_STATUS, 32'h0010_0000);
		rd(8'h1C, 32'h0000_0000);
		pw(9'h000, 1'b1, OP_JUMP, 8'h00, 8'h01, 16'h1000);
		pw(9'h001, 1'b1, OP_LOADC, 8'h02, 8'h02, 16'h1001);
		pw(9'h002, 1'b1, OP_LOOPNZ, 8'h02, 8'h03, 16'h1002);
		pw(9'h003, 1'b1, OP_CALL, 8'h05, 8'h04, 16'h1003);
		pw(9'h005, 1'b1, OP_RETURN, 8'h00, 8'h00, 16'h1005);
		pw(9'h004, 1'b0, OP_JUMP_D, 8'h06, 8'h00, 16'h1004);
		pw(9'h006, 1'b1, OP_JUMP, 8'h00, 8'hC8, 16'h1006);
		for (int s = 0; s < 4; s++) begin
			pw(9'(224 + s), 1'b1, OP_JUMP, 8'h00, 8'h07, 16'(16'h2000 + s));
		end
		pw(9'h007, 1'b1, OP_PUSH_IN, 8'h00, 8'h09, 16'h1007);
		pw(9'h009, 1'b1, OP_POP_CNT, 8'h00, 8'h0A, 16'h1009);
		pw(9'h00A, 1'b1, OP_RETURN, 8'h00, 8'h00, 16'h100A);
		// Location 8: low on input 0, mid on input 1, high on input 2 or input 4 with input 7 low
		wr(`OFS_TERM_ADDR, 32'h0000_0060);
		wr(`OFS_TERM_DATA, 32'h0000_0001);
		wr(`OFS_TERM_ADDR, 32'h0000_0064);
		wr(`OFS_TERM_DATA, 32'h0000_0002);
		wr(`OFS_TERM_ADDR, 32'h0000_0068);
		wr(`OFS_TERM_DATA, 32'h0000_0004);
		wr(`OFS_TERM_DATA, 32'h0000_8010);
		wr(`OFS_CTRL, 32'h0000_0001);
		rd(`OFS_CTRL, 32'h0000_0000);
		for (int v = 0; v < 6; v++) begin
			@(posedge mclk);
			cond_set <= vec[v];
			await_f(16'h1000);
			for (int i = 0; i < 14; i++) begin
				cmp({31'h0, user_out_oe_n}, {31'h0, i == 7});
				if (i != 7) begin
					cmp({16'h0, pins}, {16'h0, (i == 9) ? br_f[v] : seq_f[i]});
				end
				@(posedge mclk);
				#1;
			end
		end
		// Endless push loop overfills the stack; top must hold the last input
		pw(9'h000, 1'b1, OP_PUSH_IN, 8'h00, 8'h00, 16'h1000);
		@(posedge mclk);
		cond_set <= 8'h5A;
		wr(`OFS_CTRL, 32'h0000_0001);
		repeat (25) @(posedge mclk);
		rd(`OFS_STATUS, 32'h001F_5A00);
		report_and_stop();
	end
endmodule : testbench
